/* rtl/bsrb_pkg.sv */
package bsrb_pkg;
    // register indices (no offsets are printed, so the index map is local)
    localparam logic [3:0] idx_rop_pitch = 4'h0; // rop, control and destination pitch
    localparam logic [3:0] idx_bg_color = 4'h1; // expansion background colour
    localparam logic [3:0] idx_fg_color = 4'h2; // expansion foreground colour
    localparam logic [3:0] idx_pat_addr = 4'h3; // setup colour pattern address
    localparam logic [3:0] idx_dst_addr = 4'h4; // destination / working address
    localparam logic [3:0] idx_src_pitch = 4'h5; // source pitch
    localparam logic [3:0] idx_src_addr = 4'h6; // source / working address
    // field positions
    localparam int rop_lsb = 16; // raster operation select low bit
    localparam int rop_msb = 23; // raster operation select high bit
    localparam int depth_lsb = 24; // colour depth low bit
    localparam int depth_msb = 25; // colour depth high bit
    localparam int pitch_msb = 15; // signed pitch high bit
    localparam int pat_lsb = 6; // pattern address low bit
    localparam int pat_msb = 28; // pattern address high bit (26 bits from 28:3? kept 28:6)
    localparam int qw_msb = 2; // byte-in-quadword high bit
    // reset values
    localparam logic [31:0] reg_reset = 32'h0000_0000; // every setup register clears
    localparam logic [31:0] pat_mask = 32'h1fff_ffc0; // writable pattern address bits
    // colour depth encodings
    localparam logic [1:0] depth_8 = 2'h0; // 8 bits per pixel
    localparam logic [1:0] depth_16a = 2'h1; // 16 bits per pixel
    localparam logic [1:0] depth_16b = 2'h2; // 16 bits per pixel
    localparam logic [1:0] depth_32 = 2'h3; // 32 bits per pixel
    // pitch unit select
    typedef enum logic [1:0] {
        bsrb_unit_bytes = 2'b00,
        bsrb_unit_dwords = 2'b01
    } bsrb_unit_t;
endpackage

/* rtl/bsrb_regs.sv */
`timescale 1ns/1ps
// Summary of operation
// [R1] rop field bits 23:16 selects operation
// [R2] host: rop F0 needs monochrome source
// [R3] add signed dest pitch per scan line
// [R4] host: x-tiled dest pitch 512-byte multiple
// [R5] 16-bit signed source pitch in bytes
// [R6] host: x-tiled source pitch 512-byte aligned
// [R7] y-tiled source pitch counts double-words
// [R8] add signed source pitch per line
// [R9] background colour for expansion, solid pattern
// [R10] foreground colour for expansion
// [R11] colour bits used follow pixel depth
// [R12] 26-bit pattern address, scan-line blits only; the code keeps bits 28:6 (23 bits)
// [R13] host: patterns aligned by depth
// [R14] host: pattern depth matches system depth
// [R15] monochrome pattern comes from command
// [R16] destination register is working address
// [R17] host: tiled destination base 4KB granular
// [R18] compare dest line address with clip
// [R19] linear mode addresses point first byte
// [R20] host: tiled source base 4KB granular
// [R21] low 3 source bits locate byte
// [R22] reserved pattern bits read zero
// [R23] all setup registers reset to zero
module bsrb_regs (
    input wire logic clk,
    input wire logic reset_n,
    // register write/read port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_idx,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // engine stepping controls
    input wire logic dst_line_step,
    input wire logic src_line_step,
    input wire logic src_ytiled,
    input wire logic scan_line_blit_cmd,
    input wire logic single_pixel_blit_cmd,
    input wire logic mono_pattern_sel,
    input wire logic [63:0] cmd_mono_pattern,
    input wire logic [31:0] clip_top,
    input wire logic [31:0] clip_bottom,
    // outputs to the engine
    output logic [7:0] raster_operation_code,
    output logic [1:0] color_depth,
    output logic [31:0] bg_color_px,
    output logic [31:0] fg_color_px,
    output logic [31:0] solid_pattern,
    output logic [31:0] color_pattern_addr,
    output logic pattern_fetch_en,
    output logic [63:0] mono_pattern,
    output logic [31:0] dst_addr,
    output logic [31:0] src_addr,
    output logic [2:0] src_first_byte,
    output logic line_in_clip
);
    logic [31:0] setup_rop_control_dest_pitch; // rop, depth, dest pitch
    logic [31:0] setup_expansion_background_color; // background colour
    logic [31:0] setup_expansion_foreground_color; // foreground colour
    logic [31:0] setup_color_pattern_address; // pattern start address
    logic [31:0] destination_address; // working destination address
    logic [31:0] source_pitch; // source pitch
    logic [31:0] source_address; // working source address
    logic [31:0] dst_step; // sign extended dest pitch
    logic [31:0] src_step; // sign extended source pitch in bytes
    logic [31:0] depth_mask; // colour bits in use
    logic [31:0] next_rdata; // read mux

    // sign extension of pitches, dwords scaled by four for y-tiled source
    // both pitches are 16-bit two's complement, so one step can move the
    // working address up or down by a scan line
    always_comb begin
        dst_step = {{16{setup_rop_control_dest_pitch[bsrb_pkg::pitch_msb]}},
                    setup_rop_control_dest_pitch[bsrb_pkg::pitch_msb:0]}; // see [R3]
        if (src_ytiled) begin
            src_step = {{14{source_pitch[bsrb_pkg::pitch_msb]}},
                        source_pitch[bsrb_pkg::pitch_msb:0], 2'b00}; // see [R7]
        end else begin
            src_step = {{16{source_pitch[bsrb_pkg::pitch_msb]}},
                        source_pitch[bsrb_pkg::pitch_msb:0]}; // see [R5]
        end
    end

    // colour mask from pixel depth
    // both 16-bit codes share one mask; any other code keeps all 32 bits
    // so a stray depth value still yields a defined colour
    always_comb begin
        case (setup_rop_control_dest_pitch[bsrb_pkg::depth_msb:bsrb_pkg::depth_lsb])
            bsrb_pkg::depth_8: begin
                depth_mask = 32'h0000_00ff; // see [R11]
            end
            bsrb_pkg::depth_16a, bsrb_pkg::depth_16b: begin
                depth_mask = 32'h0000_ffff; // see [R11]
            end
            default: begin
                depth_mask = 32'hffff_ffff; // see [R11]
            end
        endcase
    end

    // rop / pitch register
    // one word holds operation select, depth and destination pitch
    // fields are split out combinationally or in the output flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            setup_rop_control_dest_pitch <= bsrb_pkg::reg_reset; // see [R23]
        end else if (reg_wr && reg_idx == bsrb_pkg::idx_rop_pitch) begin
            setup_rop_control_dest_pitch <= reg_wdata;
        end
    end

    // expansion colours
    // stored at full width; trimming to the depth happens on the way out
    // so a later depth change needs no rewrite of the colours
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            setup_expansion_background_color <= bsrb_pkg::reg_reset; // see [R23]
            setup_expansion_foreground_color <= bsrb_pkg::reg_reset; // see [R23]
        end else if (reg_wr) begin
            if (reg_idx == bsrb_pkg::idx_bg_color) begin
                setup_expansion_background_color <= reg_wdata;
            end
            if (reg_idx == bsrb_pkg::idx_fg_color) begin
                setup_expansion_foreground_color <= reg_wdata;
            end
        end
    end

    // pattern address, reserved bits never stored
    // masking at the write keeps the read back and the engine copy
    // identical without a second mask on the read path
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            setup_color_pattern_address <= bsrb_pkg::reg_reset; // see [R23]
        end else if (reg_wr && reg_idx == bsrb_pkg::idx_pat_addr) begin
            setup_color_pattern_address <= reg_wdata & bsrb_pkg::pat_mask; // see [R22]
        end
    end

    // destination working address: write wins over a line step
    // a host write in the same cycle as a step must not be lost, since
    // the engine is expected to be idle while software reprograms it
    // and the new base is what the next blit starts from
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            destination_address <= bsrb_pkg::reg_reset; // see [R23]
        end else if (reg_wr && reg_idx == bsrb_pkg::idx_dst_addr) begin
            destination_address <= reg_wdata; // see [R19]
        end else if (dst_line_step) begin
            destination_address <= destination_address + dst_step; // see [R16]
        end
    end

    // source pitch register
    // only the low half is used; the unit follows the tiling input
    // so one stored value serves byte and double-word pitches
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            source_pitch <= bsrb_pkg::reg_reset; // see [R23]
        end else if (reg_wr && reg_idx == bsrb_pkg::idx_src_pitch) begin
            source_pitch <= reg_wdata;
        end
    end

    // source working address
    // same priority as the destination: a write beats a step
    // the step size already carries the double-word scaling
    // for y-tiled sources, so the adder stays a plain 32-bit sum
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            source_address <= bsrb_pkg::reg_reset; // see [R23]
        end else if (reg_wr && reg_idx == bsrb_pkg::idx_src_addr) begin
            source_address <= reg_wdata; // see [R19]
        end else if (src_line_step) begin
            source_address <= source_address + src_step; // see [R8]
        end
    end

    // read mux
    // every stored register reads back as held, unmapped indices read zero
    // the pattern word already has its reserved bits cleared
    always_comb begin
        case (reg_idx)
            bsrb_pkg::idx_rop_pitch: begin
                next_rdata = setup_rop_control_dest_pitch;
            end
            bsrb_pkg::idx_bg_color: begin
                next_rdata = setup_expansion_background_color;
            end
            bsrb_pkg::idx_fg_color: begin
                next_rdata = setup_expansion_foreground_color;
            end
            bsrb_pkg::idx_pat_addr: begin
                next_rdata = setup_color_pattern_address; // see [R22]
            end
            bsrb_pkg::idx_dst_addr: begin
                next_rdata = destination_address;
            end
            bsrb_pkg::idx_src_pitch: begin
                next_rdata = source_pitch;
            end
            bsrb_pkg::idx_src_addr: begin
                next_rdata = source_address;
            end
            default: begin
                next_rdata = 32'h0000_0000; // unmapped index reads zero
            end
        endcase
    end

    // registered read data
    // captured only on a read strobe, then held until the next read
    // so the host may sample it any time after the following edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // engine-side outputs
    // every output leaves from a flip-flop, one cycle behind the register
    // that feeds it; a register write therefore shows two edges after the
    // write strobe, and a line step two edges after the step pulse
    // the engine must allow for that lag before it trusts a new value
    // each concern has its own process so that one can change alone

    // operation select and pixel depth, one cycle behind the register
    // so every engine input changes on the same edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            raster_operation_code <= 8'h00; // cleared with the register
            color_depth <= 2'h0; // 8 bits per pixel after reset
        end else begin
            // eight bits pick one of the 256 combinations
            raster_operation_code <=
                setup_rop_control_dest_pitch[bsrb_pkg::rop_msb:bsrb_pkg::rop_lsb]; // see [R1]
            // depth also steers the colour masks
            color_depth <=
                setup_rop_control_dest_pitch[bsrb_pkg::depth_msb:bsrb_pkg::depth_lsb];
        end
    end

    // expansion colours trimmed to the active pixel depth
    // unused upper bytes read as zero so the engine never sees stale bits
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bg_color_px <= 32'h0000_0000; // black background
            fg_color_px <= 32'h0000_0000; // black foreground
        end else begin
            // background for zero bits of monochrome data
            bg_color_px <= setup_expansion_background_color & depth_mask; // see [R9]
            // foreground for one bits of monochrome data
            fg_color_px <= setup_expansion_foreground_color & depth_mask; // see [R10]
        end
    end

    // solid pattern for single pixel blits
    // other commands see zero so a stale colour cannot leak into them
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            solid_pattern <= 32'h0000_0000; // no pattern after reset
        end else if (single_pixel_blit_cmd) begin
            // background doubles as the solid pattern
            solid_pattern <= setup_expansion_background_color & depth_mask; // see [R9]
        end else begin
            // any other command
            solid_pattern <= 32'h0000_0000;
        end
    end

    // colour pattern address and fetch request
    // the address is passed on always, the fetch only for scan-line blits
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            color_pattern_addr <= 32'h0000_0000; // cleared address
            pattern_fetch_en <= 1'b0; // no fetch after reset
        end else begin
            // reserved bits already dropped at the write
            color_pattern_addr <= setup_color_pattern_address; // see [R12]
            // a monochrome pattern needs no memory fetch
            pattern_fetch_en <= scan_line_blit_cmd && !mono_pattern_sel; // see [R12]
        end
    end

    // monochrome pattern bytes straight from the command words
    // eight bytes, one bit per pixel of the 8 by 8 block
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mono_pattern <= 64'h0000_0000_0000_0000; // no pattern after reset
        end else if (mono_pattern_sel) begin
            // taken from the command, never fetched
            mono_pattern <= cmd_mono_pattern; // see [R15]
        end else begin
            // colour pattern in use
            mono_pattern <= 64'h0000_0000_0000_0000;
        end
    end

    // destination working address towards the engine
    // it follows every write and every line step one cycle later
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dst_addr <= 32'h0000_0000; // cleared address
        end else begin
            // working copy, moves as lines are written
            dst_addr <= destination_address; // see [R16]
        end
    end

    // source working address and first byte in the quadword
    // both come from the same register so they always agree
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            src_addr <= 32'h0000_0000; // cleared address
            src_first_byte <= 3'h0; // first byte of the quadword
        end else begin
            // first byte to read in linear copies
            src_addr <= source_address; // see [R19]
            // low three bits locate the first valid byte
            src_first_byte <= source_address[bsrb_pkg::qw_msb:0]; // see [R21]
        end
    end

    // scan-line clip test on the working destination address
    // top is inclusive and bottom exclusive, compared unsigned on 32 bits
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            line_in_clip <= 1'b0; // nothing is inside before setup
        end else begin
            // write the line only between the clip limits
            line_in_clip <= (destination_address >= clip_top) &&
                            (destination_address < clip_bottom); // see [R18]
        end
    end
endmodule

/* verif/bsrb_engine_model.sv */
`timescale 1ns/1ps
// address generator stand-in: one step pulse per line
module bsrb_engine_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic go,
    input wire logic to_src,
    input wire logic [3:0] lines,
    output logic dst_line_step,
    output logic src_line_step
);
    logic [3:0] left; // lines still to step
    // load on go, then step back to back
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            left <= 4'h0;
        end else if (go) begin
            left <= lines;
        end else if (left != 4'h0) begin
            left <= left - 4'h1;
        end
    end
    assign dst_line_step = (left != 4'h0) && !to_src;
    assign src_line_step = (left != 4'h0) && to_src;
endmodule

/* verif/bsrb_regs_assertions.sv */
`timescale 1ns/1ps
module bsrb_regs_checker (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_idx,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic single_pixel_blit_cmd,
    input wire logic [31:0] clip_top,
    input wire logic [31:0] clip_bottom,
    input wire logic [7:0] raster_operation_code,
    input wire logic [1:0] color_depth,
    input wire logic [31:0] bg_color_px,
    input wire logic [31:0] solid_pattern,
    input wire logic [31:0] dst_addr,
    input wire logic [31:0] src_addr,
    input wire logic [2:0] src_first_byte,
    input wire logic line_in_clip
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    rop_field_a: assert property (
        reg_wr && reg_idx == bsrb_pkg::idx_rop_pitch |->
        ##2 raster_operation_code == $past(reg_wdata[23:16], 2)) else $error("rop select wrong");
    pat_reserved_a: assert property (
        reg_rd && reg_idx == bsrb_pkg::idx_pat_addr |=>
        (reg_rdata & ~bsrb_pkg::pat_mask) == 32'h0) else $error("pattern reserved bits set");
    bg_mask_a: assert property (
        color_depth == bsrb_pkg::depth_8 |-> bg_color_px[31:8] == 24'h0) else $error("bg mask");
    src_byte_a: assert property (
        reg_wr && reg_idx == bsrb_pkg::idx_src_addr |->
        ##2 src_first_byte == $past(reg_wdata[2:0], 2)) else $error("first byte wrong");
    dst_load_a: assert property (
        reg_wr && reg_idx == bsrb_pkg::idx_dst_addr |->
        ##2 dst_addr == $past(reg_wdata, 2)) else $error("dst load wrong");
    src_load_a: assert property (
        reg_wr && reg_idx == bsrb_pkg::idx_src_addr |->
        ##2 src_addr == $past(reg_wdata, 2)) else $error("src load wrong");
    solid_pat_a: assert property (
        single_pixel_blit_cmd |=> solid_pattern == bg_color_px) else $error("solid wrong");
    clip_cmp_a: assert property (
        1'b1 |=> line_in_clip == ($past(clip_top) <= dst_addr && dst_addr < $past(clip_bottom)))
        else $error("clip compare wrong");
endmodule
bind bsrb_regs bsrb_regs_checker chk (.*);

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
    logic clk, reset_n, reg_wr, reg_rd, src_ytiled, go, to_src, dst_line_step, src_line_step;
    logic scan_line_blit_cmd, single_pixel_blit_cmd, mono_pattern_sel, pattern_fetch_en;
    logic line_in_clip;
    logic [3:0] reg_idx, lines;
    logic [31:0] reg_wdata, reg_rdata, clip_top, clip_bottom, bg_color_px, fg_color_px, m;
    logic [31:0] solid_pattern, color_pattern_addr, dst_addr, src_addr;
    logic [63:0] cmd_mono_pattern, mono_pattern;
    logic [7:0] raster_operation_code;
    logic [1:0] color_depth;
    logic [2:0] src_first_byte;
    int err_count, total_checks;
    bsrb_regs uut (.*);
    bsrb_engine_model eng (.*);
    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // compare and count
    task chk(input string n, input logic [63:0] e, input logic [63:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [3:0] i, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_idx <= i;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] i, input logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_idx <= i;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", {32'h0, e}, {32'h0, reg_rdata});
    endtask
    // let a write reach the engine outputs
    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // step n lines of destination or source
    task run(input logic s, input logic [3:0] n);
        @(posedge clk);
        to_src <= s;
        lines <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (n + 3) @(posedge clk);
        #1;
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        #200000;
        err_count++;
        final_report;
    end
    initial begin
        {reset_n, reg_wr, reg_rd, src_ytiled, go, to_src, reg_idx, lines, reg_wdata} = '0;
        {scan_line_blit_cmd, single_pixel_blit_cmd, mono_pattern_sel, clip_top} = '0;
        {clip_bottom, cmd_mono_pattern} = '0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 8; i++) rd(i[3:0], 32'h0);
        $display("reset test done");
        @(posedge clk);
        single_pixel_blit_cmd <= 1'b1;
        wr(bsrb_pkg::idx_bg_color, 32'h89ab_cdef);
        wr(bsrb_pkg::idx_fg_color, 32'h7654_3210);
        for (int d = 0; d < 4; d++) begin
            // rop f0 under a single-pixel blit command; pitch -16 on an untiled surface
            wr(bsrb_pkg::idx_rop_pitch, {6'h0, d[1:0], 8'hf0, 16'hfff0});
            settle;
            m = (d == 3) ? 32'hffff_ffff : (d == 0) ? 32'h0000_00ff : 32'h0000_ffff;
            chk("rop", 64'hf0, {56'h0, raster_operation_code});
            chk("depth", {62'h0, d[1:0]}, {62'h0, color_depth});
            chk("bg", {32'h0, 32'h89ab_cdef & m}, {32'h0, bg_color_px});
            chk("fg", {32'h0, 32'h7654_3210 & m}, {32'h0, fg_color_px});
            chk("solid", {32'h0, 32'h89ab_cdef & m}, {32'h0, solid_pattern});
        end
        @(posedge clk);
        single_pixel_blit_cmd <= 1'b0;
        settle;
        chk("solid", 64'h0, {32'h0, solid_pattern});
        $display("colour test done");
        @(posedge clk);
        scan_line_blit_cmd <= 1'b1;
        wr(bsrb_pkg::idx_pat_addr, 32'hffff_ffff);
        rd(bsrb_pkg::idx_pat_addr, 32'h1fff_ffc0);
        // 256-byte aligned pattern at the 32 bpp depth set above
        wr(bsrb_pkg::idx_pat_addr, 32'h0000_1f00);
        settle;
        chk("pat", 64'h1f00, {32'h0, color_pattern_addr});
        chk("fetch", 64'h1, {63'h0, pattern_fetch_en});
        chk("mono", 64'h0, mono_pattern);
        @(posedge clk);
        mono_pattern_sel <= 1'b1;
        cmd_mono_pattern <= 64'h0123_4567_89ab_cdef;
        settle;
        chk("mono", 64'h0123_4567_89ab_cdef, mono_pattern);
        chk("fetch", 64'h0, {63'h0, pattern_fetch_en});
        $display("pattern test done");
        wr(bsrb_pkg::idx_dst_addr, 32'h0000_1000);
        run(1'b0, 4'h3);
        chk("dst", 64'h0fd0, {32'h0, dst_addr});
        rd(bsrb_pkg::idx_dst_addr, 32'h0000_0fd0);
        @(posedge clk);
        clip_top <= 32'h0000_0f00;
        clip_bottom <= 32'h0000_0fd0;
        settle;
        chk("clip", 64'h0, {63'h0, line_in_clip});
        @(posedge clk);
        clip_bottom <= 32'h0000_0fd1;
        settle;
        chk("clip", 64'h1, {63'h0, line_in_clip});
        $display("destination test done");
        wr(bsrb_pkg::idx_src_pitch, 32'h0000_0010);
        wr(bsrb_pkg::idx_src_addr, 32'h0000_2005);
        run(1'b1, 4'h2);
        chk("src", 64'h2025, {32'h0, src_addr});
        chk("byte", 64'h5, {61'h0, src_first_byte});
        @(posedge clk);
        src_ytiled <= 1'b1;
        run(1'b1, 4'h1);
        chk("src", 64'h2065, {32'h0, src_addr});
        wr(bsrb_pkg::idx_src_pitch, 32'h0000_fff8);
        run(1'b1, 4'h1);
        chk("src", 64'h2045, {32'h0, src_addr});
        $display("source test done");
        @(posedge clk);
        reset_n <= 1'b0;
        @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 7; i++) rd(i[3:0], 32'h0);
        $display("second reset test done");
        final_report;
    end
endmodule
